/* test/dio_checker.sv */
// Purpose: port-level checks of the line bank and its wait engine
// Assumes: one clock; ce_i stays high while a wait runs
// Notes:   a start is seen at the access edge of a wait config write
`timescale 1ns/10ps
`include "dio_consts.svh"
module dio_checker (
  input wire logic                   clk_sys_i,
  input wire logic                   nrst_i,
  input wire logic                   ce_i,
  input wire logic                   psel_i,
  input wire logic                   penable_i,
  input wire logic                   pwrite_i,
  input wire logic [`DIO_ADDR_W-1:0] paddr_i,
  input wire logic [`DIO_DATA_W-1:0] pwdata_i,
  input wire logic                   pready_o,
  input wire logic                   pslverr_o,
  input wire logic                   wait_busy_o,
  input wire logic                   wait_done_o,
  input wire logic                   wait_timed_out_o
);
  logic        start_ev;
  logic [31:0] tmo_ff;
  logic [31:0] cur_ff;
  logic [31:0] cnt_ff;
  ////////////////////////////////////////////////////////////////////////////
  // start as the bank takes it; a start while busy is refused
  assign start_ev = psel_i && penable_i && pwrite_i && ce_i && !wait_busy_o
    && paddr_i == `DIO_WAIT_CFG && pwdata_i[`DIO_WCFG_START_BIT];
  // timeout shadow and cycles since the start edge
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tmo_ff <= 32'h0;
      cur_ff <= 32'h0;
      cnt_ff <= 32'h0;
    end
    else if (ce_i)
    begin
      if (psel_i && penable_i && pwrite_i && paddr_i == `DIO_WAIT_TMO)
        tmo_ff <= pwdata_i;
      cur_ff <= start_ev ? tmo_ff : cur_ff;
      cnt_ff <= start_ev ? 32'h0 : cnt_ff + 32'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  AST_READY: assert property (psel_i && penable_i |-> pready_o)
    else $error("no ready in access phase");
  AST_IDLE_READY: assert property (!penable_i |-> !pready_o)
    else $error("ready outside access phase");
  AST_ERR_PHASE: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("slave error outside access phase");
  AST_DONE_PULSE: assert property (wait_done_o |=> !wait_done_o)
    else $error("done longer than one cycle");
  AST_BUSY_START: assert property (start_ev |=> wait_busy_o)
    else $error("busy missing after start");
  AST_BUSY_CAUSE: assert property ($rose(wait_busy_o) |-> $past(start_ev))
    else $error("busy without start");
  AST_TMO_ZERO: assert property (start_ev && tmo_ff == 32'h0 |->
    ##2 wait_done_o ##1 wait_timed_out_o)
    else $error("zero timeout not immediate");
  AST_TMO_BOUND: assert property (wait_busy_o && !cur_ff[31] |->
    cnt_ff <= cur_ff + 32'h1)
    else $error("wait ran past its timeout");
  AST_EARLY_CLEAR: assert property (wait_done_o &&
    (cur_ff[31] || cnt_ff < cur_ff + 32'h1) |=> !wait_timed_out_o)
    else $error("timeout flag on a released wait");
endmodule : dio_checker

bind digital_io_wait_timeout dio_checker u_dio_checker (
  .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
  .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .wait_busy_o(wait_busy_o), .wait_done_o(wait_done_o),
  .wait_timed_out_o(wait_timed_out_o));

/* test/ext_lines.sv */
// Purpose: outside signals wired to the connector and trigger pins
// Assumes: the outside world holds every pin that the bank leaves free
// Notes:   where both sides drive, the bank's value is what the pin shows
`timescale 1ns/10ps
module ext_lines #(
  parameter int W = 160
)
(
  input  wire logic [W-1:0] drv_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] ext_i,
  output logic [W-1:0]      pin_o
);
  ////////////////////////////////////////////////////////////////////////////
  // wire level fed back to the sampling side of the bank
  assign pin_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : ext_lines

/* test/test_digital_io_wait_timeout.sv */
// Purpose: self-checking bench of the line bank over APB
// Assumes: outside signals always drive the free pins
// Notes:   waits watch line 152, whose group is left undriven by the bank
`timescale 1ns/10ps
`include "dio_consts.svh"
module test_digital_io_wait_timeout;
  import dio_pkg::*;
  logic clk_sys_i = 1'b0, nrst_i = 1'b0, psel = 1'b0, pen = 1'b0;
  logic pwr = 1'b0, pready, pslverr, busy, done, tmo_flag;
  logic [11:0]  paddr = 12'h0;
  logic [31:0]  pwdata = 32'h0, prdata;
  logic [159:0] pin, dout, doe, xval = 160'h0, uout = 160'h0, uoe = 160'h0;
  logic [8:0]   tpin, tout, toe, txval = 9'h0;
  logic [28:0]  ureq = 29'h0;
  logic [7:0]   outv [20];
  int           failures = 0, checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #10 clk_sys_i = ~clk_sys_i;
  digital_io_wait_timeout u_digital_io_wait_timeout (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(1'b1), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .digital_line_i(pin), .digital_line_o(dout), .digital_line_oe_o(doe),
    .system_trigger_line_i(tpin), .system_trigger_line_o(tout),
    .system_trigger_line_oe_o(toe), .usr_req_i(ureq),
    .usr_line_out_i(uout), .usr_line_oe_i(uoe), .usr_trig_out_i(9'h0),
    .usr_trig_oe_i(9'h0), .wait_busy_o(busy), .wait_done_o(done),
    .wait_timed_out_o(tmo_flag));
  ext_lines #(.W(160)) u_ext_lines (.drv_i(dout), .oe_i(doe),
    .ext_i(xval), .pin_o(pin));
  ext_lines #(.W(9)) u_ext_lines_trig (.drv_i(tout), .oe_i(toe),
    .ext_i(txval), .pin_o(tpin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one APB transfer; held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do
      @(posedge clk_sys_i);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic err_case(input logic wr, input logic [11:0] a,
                          input logic [31:0] d, input logic ex);
    logic [31:0] rd;
    logic        er;
    apb(wr, a, d, rd, er);
    chk("slave error", er, ex);
  endtask : err_case
  // timed out unless the condition shows before the timeout
  function automatic logic exp_to(input int md, input logic lvl, tog,
                                  input int tmo);
    if (tmo == 0)
      return 1'b1;
    case (md)
      0: return !(tog && !lvl);
      1: return !(tog && lvl);
      2: return !tog;
      3: return !(lvl || tog);
      default: return !(!lvl || tog);
    endcase
  endfunction : exp_to
  // line 152 set to lvl, wait started, toggled 5 cycles later if tog
  task automatic run_wait(input int md, input logic lvl, tog, input int tmo);
    logic [31:0] rd;
    logic        er;
    logic        ex;
    int          n;
    ex = exp_to(md, lvl, tog, tmo);
    xval[152] <= lvl;
    repeat (3) @(posedge clk_sys_i);
    apb(1'b1, `DIO_WAIT_TMO, tmo, rd, er);
    apb(1'b1, `DIO_WAIT_CFG, {15'h0, 1'b1, 8'h98, 5'h0, md[2:0]}, rd, er);
    n = 0;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (tog && n == 5)
        xval[152] <= ~lvl;
    end
    while (done !== 1'b1 && n < 300);
    if (tmo > 0 && ex)
      chk("span", n, tmo + 2);
    if (tmo == 0)
      chk("zero span", n, 2);
    apb(1'b0, `DIO_WAIT_STAT, 32'h0, rd, er);
    chk("stat", rd & 32'h6, {ex, 2'b10});
    chk("result", tmo_flag, ex);
    $display("wait test mode %0d level %0d toggle %0d ended", md, lvl, tog);
  endtask : run_wait
  task automatic wrap_up;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the fewer than 1500 cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    wrap_up();
  end
  initial
  begin
    logic [31:0] rd;
    logic        er;
    logic        lvl;
    logic        tog;
    int          tmo;
    rd = $urandom(32'h7404541E);
    xval = {$urandom, $urandom, $urandom, $urandom, $urandom};
    txval = 9'($urandom);
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    // group writes, drive and loop-back through the pins
    for (int k = 0; k < 20; k++)
    begin
      outv[k] = 8'($urandom);
      apb(1'b1, `DIO_OUT_BASE + 12'(4 * k), {24'h0, outv[k]}, rd, er);
      apb(1'b1, `DIO_OEN_BASE + 12'(4 * k), (k == 19) ? 0 : 32'hFF, rd, er);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk("drive", dout[8*k+:8], outv[k]);
      chk("enable", doe[8*k+:8], (k == 19) ? 0 : 8'hFF);
      apb(1'b0, `DIO_IN_BASE + 12'(4 * k), 32'h0, rd, er);
      chk("input", rd, (k == 19) ? xval[159:152] : outv[k]);
    end
    $display("group test ended");
    // second user on group 0, then software wins by scheme bit
    uout[7:0] <= 8'h5A;
    uoe[7:0] <= 8'hFF;
    ureq[0] <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("user wins", dout[7:0], 8'h5A);
    apb(1'b1, `DIO_ARB_CFG, 32'h1, rd, er);
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk("software wins", dout[7:0], outv[0]);
    $display("arbitration test ended");
    // oscillator line as one more trigger channel
    apb(1'b1, `DIO_TRIG_OUT, 32'h100, rd, er);
    apb(1'b1, `DIO_TRIG_OEN, 32'h100, rd, er);
    repeat (3) @(posedge clk_sys_i);
    apb(1'b0, `DIO_TRIG_IN, 32'h0, rd, er);
    chk("trigger in", rd, {1'b1, txval[7:0]});
    chk("osc drive", {toe[8], tout[8]}, 2'b11);
    // group 3 line-wise; group write refused, line write keeps others
    err_case(1'b1, `DIO_PORT_MODE, 32'h8, 1'b0);
    err_case(1'b1, `DIO_OUT_BASE + 12'hC, 32'h0, 1'b1);
    err_case(1'b1, `DIO_LINE_CTRL, {22'h0, 1'b1, ~outv[3][2], 8'h1A},
             1'b0);
    err_case(1'b1, `DIO_LINE_CTRL, 32'h3A0, 1'b1);
    err_case(1'b1, `DIO_IN_BASE, 32'h0, 1'b1);
    err_case(1'b0, 12'h1FC, 32'h0, 1'b1);
    err_case(1'b1, 12'h002, 32'h0, 1'b1);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk("line write", dout[31:24], outv[3] ^ 8'h04);
    $display("line mode test ended");
    // every wait kind, zero, positive and negative timeouts
    for (int i = 0; i < 25; i++)
    begin
      lvl = 1'($urandom);
      tog = 1'($urandom);
      tmo = 20 + int'($urandom % 20);
      if (i < 5)
        tmo = 0;
      else if (!exp_to(i % 5, lvl, tog, tmo) && i % 2 == 1)
        tmo = -1;
      run_wait(i % 5, lvl, tog, tmo);
    end
    wrap_up();
  end
endmodule : test_digital_io_wait_timeout

/* verilog/digital_io_wait_timeout.sv */
// Purpose: bank of connector lines and trigger lines behind APB, with waits
// Assumes: pins and user-side inputs are synchronous to clk_sys_i
// Notes:   APB answers with no wait states; read data taken at setup
//
// Functional notes
// - lines are grouped into eight-line groups accessed as one value.
// - an output group is written either group-wide or line-wise, never both.
// - the any-edge wait releases on the next change in either direction.
// - every wait takes a signed timeout counted in device clock cycles.
// - a zero timeout ends the wait at once as a timeout.
// - a negative timeout disables the timeout entirely.
// - a positive timeout N lets the wait run up to N cycles, then times out.
// - the falling-edge wait releases only on the next high-to-low change.
// - the rising-edge wait releases only on the next low-to-high change.
// - the high-level wait releases once the line is seen high, even at once.
// - the low-level wait releases once the line is seen low, even at once.
// - group k holds lines 8k to 8k+7, lowest line in bit zero.
// - there are 160 lines on four connectors of five groups each.
// - every line has a sampled input, an output value and an output enable.
// - the oscillator line works as one more trigger channel.
// - users sharing a channel are arbitrated, scheme chosen per channel.
`timescale 1ns/10ps
`include "dio_consts.svh"
module digital_io_wait_timeout
  import dio_pkg::*;
#(
  parameter int NUM_CONN       = `DIO_NUM_CONN,
  parameter int PORTS_PER_CONN = `DIO_PORTS_PER_CONN,
  parameter int NUM_TRIG       = `DIO_NUM_TRIG
)
(
  input  wire logic                                clk_sys_i,
  input  wire logic                                nrst_i,
  input  wire logic                                ce_i,
  // APB slave
  input  wire logic                                psel_i,
  input  wire logic                                penable_i,
  input  wire logic                                pwrite_i,
  input  wire logic [`DIO_ADDR_W-1:0]              paddr_i,
  input  wire logic [`DIO_DATA_W-1:0]              pwdata_i,
  output logic [`DIO_DATA_W-1:0]                   prdata_o,
  output logic                                     pready_o,
  output logic                                     pslverr_o,
  // connector lines
  input  wire logic [NUM_CONN*PORTS_PER_CONN*8-1:0] digital_line_i,
  output logic [NUM_CONN*PORTS_PER_CONN*8-1:0]      digital_line_o,
  output logic [NUM_CONN*PORTS_PER_CONN*8-1:0]      digital_line_oe_o,
  // trigger lines, top bit is the oscillator line
  input  wire logic [NUM_TRIG:0]                   system_trigger_line_i,
  output logic [NUM_TRIG:0]                        system_trigger_line_o,
  output logic [NUM_TRIG:0]                        system_trigger_line_oe_o,
  // second internal user, one request per channel
  input  wire logic [NUM_CONN*PORTS_PER_CONN+NUM_TRIG:0] usr_req_i,
  input  wire logic [NUM_CONN*PORTS_PER_CONN*8-1:0] usr_line_out_i,
  input  wire logic [NUM_CONN*PORTS_PER_CONN*8-1:0] usr_line_oe_i,
  input  wire logic [NUM_TRIG:0]                   usr_trig_out_i,
  input  wire logic [NUM_TRIG:0]                   usr_trig_oe_i,
  // wait status for user logic
  output logic                                     wait_busy_o,
  output logic                                     wait_done_o,
  output logic                                     wait_timed_out_o
);

  localparam int LPP = `DIO_LINES_PER_PORT;
  localparam int NP  = NUM_CONN * PORTS_PER_CONN;
  localparam int NL  = NP * LPP;
  localparam int NT  = NUM_TRIG + 1;
  localparam int NCH = NP + NT;
  localparam int NW  = NL + NT;

  ////////////////////////////////////////////////////////////////////////
  // refuse sizes the map cannot hold
  if (NCH > `DIO_DATA_W || NT > `DIO_DATA_W || NP > 32 ||
      NW > (1 << `DIO_CH_W) || NUM_CONN < 1 || PORTS_PER_CONN < 1)
  begin : g_bad_size
    $error("digital_io_wait_timeout: sizes exceed the register map");
  end

  typedef struct packed {
    logic [NL-1:0]          out;
    logic [NL-1:0]          oe;
    logic [NL-1:0]          smp;
    logic [NP-1:0]          line_mode;
    logic [NT-1:0]          t_out;
    logic [NT-1:0]          t_oe;
    logic [NT-1:0]          t_smp;
    logic [NCH-1:0]         arb;
    wait_mode_t             w_mode;
    logic [`DIO_CH_W-1:0]   w_ch;
    logic [31:0]            w_tmo;
    logic                   w_start;
    logic                   w_done;
    logic                   w_to;
    logic [`DIO_DATA_W-1:0] rdata;
    logic [NL-1:0]          pin_out;
    logic [NL-1:0]          pin_oe;
    logic [NT-1:0]          tpin_out;
    logic [NT-1:0]          tpin_oe;
  } regs_t;

  regs_t               r_ff;
  regs_t               nxt_r;
  logic [NCH-1:0]      gnt_usr;
  logic [NL-1:0]       drv_out;
  logic [NL-1:0]       drv_oe;
  logic [NT-1:0]       tdrv_out;
  logic [NT-1:0]       tdrv_oe;
  logic [NW-1:0]       all_smp;
  logic                wait_sig;
  wait_req_t           w_req;
  wait_rsp_t           w_rsp;
  logic                setup_ph;
  logic                wr_acc;
  logic                bad_acc;
  logic [4:0]          widx;
  logic [`DIO_ADDR_W-1:0] wbase;
  logic [`DIO_CH_W-1:0] lidx;

  ////////////////////////////////////////////////////////////////////////
  // per-channel arbitration between software and the user port
  for (genvar c = 0; c < NCH; c++)
  begin : g_arb
    logic sw_claims;
    if (c < NP)
    begin : g_grp
      assign sw_claims = |r_ff.oe[c*LPP +: LPP];
    end
    else
    begin : g_trg
      assign sw_claims = r_ff.t_oe[c-NP];
    end
    // scheme 0: user first; scheme 1: software first while it drives
    assign gnt_usr[c] = usr_req_i[c] & (~r_ff.arb[c] | ~sw_claims);
  end

  // expand grants onto lines, one value per group
  always_comb
  begin
    for (int i = 0; i < NL; i++)
    begin
      drv_out[i] = gnt_usr[i/LPP] ? usr_line_out_i[i] : r_ff.out[i];
      drv_oe[i]  = gnt_usr[i/LPP] ? usr_line_oe_i[i]  : r_ff.oe[i];
    end
    for (int t = 0; t < NT; t++)
    begin
      tdrv_out[t] = gnt_usr[NP+t] ? usr_trig_out_i[t] : r_ff.t_out[t];
      tdrv_oe[t]  = gnt_usr[NP+t] ? usr_trig_oe_i[t]  : r_ff.t_oe[t];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wait engine on the selected sampled line or trigger
  assign all_smp = {r_ff.t_smp, r_ff.smp};
  assign wait_sig = (r_ff.w_ch < NW) ? all_smp[r_ff.w_ch] : 1'b0;
  assign w_req.start = r_ff.w_start;
  assign w_req.mode  = r_ff.w_mode;
  assign w_req.tmo   = r_ff.w_tmo;

  wait_engine u_wait
  (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .req_i     (w_req),
    .sig_i     (wait_sig),
    .rsp_o     (w_rsp)
  );

  ////////////////////////////////////////////////////////////////////////
  // APB decode: read at setup, write at access
  assign setup_ph = psel_i & ~penable_i;
  assign wr_acc   = psel_i & penable_i & pwrite_i & ~bad_acc;
  assign widx     = paddr_i[6:2];
  assign wbase    = {paddr_i[`DIO_ADDR_W-1:7], 7'h00};
  assign lidx     = pwdata_i[`DIO_CH_W-1:0];

  // unmapped, misaligned, or a write against the group's access style
  always_comb
  begin
    bad_acc = 1'b0;
    if (paddr_i[1:0] != 2'h0)
      bad_acc = 1'b1;
    else if (wbase == `DIO_OUT_BASE || wbase == `DIO_OEN_BASE)
      bad_acc = (int'(widx) >= NP) ||
                (pwrite_i && r_ff.line_mode[widx]);
    else if (wbase == `DIO_IN_BASE)
      bad_acc = (int'(widx) >= NP) || pwrite_i;
    else
    begin
      case (paddr_i)
        `DIO_LINE_CTRL:
          bad_acc = pwrite_i && ((int'(lidx) >= NL) ||
                    !r_ff.line_mode[lidx/LPP]);
        `DIO_PORT_MODE, `DIO_TRIG_OUT, `DIO_TRIG_OEN,
        `DIO_ARB_CFG, `DIO_WAIT_TMO:
          bad_acc = 1'b0;
        `DIO_TRIG_IN, `DIO_WAIT_STAT:
          bad_acc = pwrite_i;
        `DIO_WAIT_CFG:
          bad_acc = pwrite_i && pwdata_i[`DIO_WCFG_START_BIT] &&
                    (w_rsp.busy || r_ff.w_start);
        default:
          bad_acc = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb
  begin
    nxt_r         = r_ff;
    nxt_r.w_start = 1'b0;
    // sample pins every cycle
    nxt_r.smp     = digital_line_i;
    nxt_r.t_smp   = system_trigger_line_i;
    // pins follow the arbitrated drive one cycle later
    nxt_r.pin_out  = drv_out;
    nxt_r.pin_oe   = drv_oe;
    nxt_r.tpin_out = tdrv_out;
    nxt_r.tpin_oe  = tdrv_oe;

    // read data captured in the setup cycle
    if (setup_ph && !pwrite_i)
    begin
      nxt_r.rdata = '0;
      if (wbase == `DIO_OUT_BASE && int'(widx) < NP)
        nxt_r.rdata[LPP-1:0] = r_ff.out[widx*LPP +: LPP];
      else if (wbase == `DIO_OEN_BASE && int'(widx) < NP)
        nxt_r.rdata[LPP-1:0] = r_ff.oe[widx*LPP +: LPP];
      else if (wbase == `DIO_IN_BASE && int'(widx) < NP)
        nxt_r.rdata[LPP-1:0] = r_ff.smp[widx*LPP +: LPP];
      else
      begin
        case (paddr_i)
          `DIO_PORT_MODE: nxt_r.rdata[NP-1:0]  = r_ff.line_mode;
          `DIO_TRIG_OUT:  nxt_r.rdata[NT-1:0]  = r_ff.t_out;
          `DIO_TRIG_OEN:  nxt_r.rdata[NT-1:0]  = r_ff.t_oe;
          `DIO_TRIG_IN:   nxt_r.rdata[NT-1:0]  = r_ff.t_smp;
          `DIO_ARB_CFG:   nxt_r.rdata[NCH-1:0] = r_ff.arb;
          `DIO_WAIT_CFG:
          begin
            nxt_r.rdata[2:0] = r_ff.w_mode;
            nxt_r.rdata[`DIO_WCFG_CH_LSB +: `DIO_CH_W] = r_ff.w_ch;
          end
          `DIO_WAIT_TMO:  nxt_r.rdata = r_ff.w_tmo;
          `DIO_WAIT_STAT:
          begin
            nxt_r.rdata[`DIO_WSTAT_BUSY_BIT] = w_rsp.busy | r_ff.w_start;
            nxt_r.rdata[`DIO_WSTAT_DONE_BIT] = r_ff.w_done;
            nxt_r.rdata[`DIO_WSTAT_TO_BIT]   = r_ff.w_to;
          end
          default:        nxt_r.rdata = '0;
        endcase
      end
    end

    // writes take effect at the access edge only
    if (wr_acc)
    begin
      if (wbase == `DIO_OUT_BASE)
        nxt_r.out[widx*LPP +: LPP] = pwdata_i[LPP-1:0];
      else if (wbase == `DIO_OEN_BASE)
        nxt_r.oe[widx*LPP +: LPP] = pwdata_i[LPP-1:0];
      else
      begin
        case (paddr_i)
          `DIO_LINE_CTRL:
          begin
            nxt_r.out[lidx] = pwdata_i[`DIO_LINE_VAL_BIT];
            nxt_r.oe[lidx]  = pwdata_i[`DIO_LINE_OE_BIT];
          end
          `DIO_PORT_MODE: nxt_r.line_mode = pwdata_i[NP-1:0];
          `DIO_TRIG_OUT:  nxt_r.t_out     = pwdata_i[NT-1:0];
          `DIO_TRIG_OEN:  nxt_r.t_oe      = pwdata_i[NT-1:0];
          `DIO_ARB_CFG:   nxt_r.arb       = pwdata_i[NCH-1:0];
          `DIO_WAIT_TMO:  nxt_r.w_tmo     = pwdata_i;
          `DIO_WAIT_CFG:
          begin
            nxt_r.w_mode  = wait_mode_t'(pwdata_i[2:0]);
            nxt_r.w_ch    = pwdata_i[`DIO_WCFG_CH_LSB +: `DIO_CH_W];
            nxt_r.w_start = pwdata_i[`DIO_WCFG_START_BIT];
          end
          default: ;
        endcase
      end
    end

    // a fresh start clears done; a finishing wait sets it and wins
    if (r_ff.w_start)
      nxt_r.w_done = 1'b0;
    if (w_rsp.done)
    begin
      nxt_r.w_done = 1'b1;
      nxt_r.w_to   = w_rsp.timed_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, frozen while the clock enable is low
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      r_ff <= '{w_mode: WAIT_RISE, default: '0};
    else if (ce_i)
      r_ff <= nxt_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign prdata_o                 = r_ff.rdata;
  assign pready_o                 = psel_i & penable_i; // no wait states
  assign pslverr_o                = psel_i & penable_i & bad_acc;
  assign digital_line_o           = r_ff.pin_out;
  assign digital_line_oe_o        = r_ff.pin_oe;
  assign system_trigger_line_o    = r_ff.tpin_out;
  assign system_trigger_line_oe_o = r_ff.tpin_oe;
  assign wait_busy_o              = w_rsp.busy | r_ff.w_start;
  assign wait_done_o              = w_rsp.done;
  assign wait_timed_out_o         = r_ff.w_to;

endmodule : digital_io_wait_timeout

/* verilog/dio_consts.svh */
// Purpose: offsets, field positions and sizes of the digital line bank
// Assumes: 32-bit APB data, 12-bit byte address
// Notes:   every register takes one aligned word
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH

// sizes
`define DIO_LINES_PER_PORT   8
`define DIO_NUM_CONN         4
`define DIO_PORTS_PER_CONN   5
`define DIO_NUM_TRIG         8
`define DIO_ADDR_W           12
`define DIO_DATA_W           32
`define DIO_CH_W             8

// register byte offsets
`define DIO_OUT_BASE         12'h000
`define DIO_OEN_BASE         12'h080
`define DIO_IN_BASE          12'h100
`define DIO_LINE_CTRL        12'h180
`define DIO_PORT_MODE        12'h184
`define DIO_TRIG_OUT         12'h188
`define DIO_TRIG_OEN         12'h18C
`define DIO_TRIG_IN          12'h190
`define DIO_ARB_CFG          12'h194
`define DIO_WAIT_CFG         12'h1A0
`define DIO_WAIT_TMO         12'h1A4
`define DIO_WAIT_STAT        12'h1A8

// field positions
`define DIO_LINE_VAL_BIT     8
`define DIO_LINE_OE_BIT      9
`define DIO_WCFG_CH_LSB      8
`define DIO_WCFG_START_BIT   16
`define DIO_WSTAT_BUSY_BIT   0
`define DIO_WSTAT_DONE_BIT   1
`define DIO_WSTAT_TO_BIT     2

`endif

/* verilog/dio_pkg.sv */
// Purpose: shared types of the digital line bank
// Assumes: nothing beyond the constants header
// Notes:   wait request and answer travel as packed structs
package dio_pkg;

  // kinds of wait
  typedef enum logic [2:0] {
    WAIT_RISE = 3'h0,
    WAIT_FALL = 3'h1,
    WAIT_ANY  = 3'h2,
    WAIT_HIGH = 3'h3,
    WAIT_LOW  = 3'h4
  } wait_mode_t;

  // gray along idle -> run -> done
  typedef enum logic [1:0] {
    WS_IDLE = 2'h0,
    WS_RUN  = 2'h1,
    WS_DONE = 2'h3
  } wait_state_t;

  typedef struct packed {
    logic               start;
    wait_mode_t         mode;
    logic signed [31:0] tmo;
  } wait_req_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic timed_out;
  } wait_rsp_t;

endpackage : dio_pkg

/* verilog/wait_engine.sv */
// Purpose: edge / level wait with a clock-tick timeout on one line
// Assumes: sig_i is already a sampled, synchronous level
// Notes:   done is a one-cycle pulse, timed_out holds until next start
`timescale 1ns/10ps
module wait_engine
  import dio_pkg::*;
(
  input  wire logic      clk_sys_i,
  input  wire logic      nrst_i,
  input  wire logic      ce_i,
  input  wire wait_req_t req_i,
  input  wire logic      sig_i,
  output wait_rsp_t      rsp_o
);

  typedef struct packed {
    wait_state_t st;
    wait_mode_t  mode;
    logic        inf;
    logic        prev;
    logic [31:0] cnt;
    logic        timed_out;
  } eng_regs_t;

  eng_regs_t r_ff;
  eng_regs_t nxt_r;
  logic      hit;
  logic      lvl_now;

  ////////////////////////////////////////////////////////////////////////
  // release conditions; edge waits against the value seen last cycle
  always_comb
  begin
    case (r_ff.mode)
      WAIT_RISE: hit = ~r_ff.prev & sig_i;
      WAIT_FALL: hit = r_ff.prev & ~sig_i;
      WAIT_ANY:  hit = r_ff.prev ^ sig_i;
      WAIT_HIGH: hit = sig_i;
      WAIT_LOW:  hit = ~sig_i;
      default:   hit = 1'b0;
    endcase
    // level waits may finish in the start cycle itself
    lvl_now = ((req_i.mode == WAIT_HIGH) & sig_i) |
              ((req_i.mode == WAIT_LOW) & ~sig_i);
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencing and timeout count
  always_comb
  begin
    nxt_r = r_ff;
    case (r_ff.st)
      WS_IDLE:
      begin
        if (req_i.start)
        begin
          nxt_r.mode      = req_i.mode;
          nxt_r.prev      = sig_i;          // only later edges count
          nxt_r.inf       = req_i.tmo[31];
          nxt_r.cnt       = req_i.tmo;
          nxt_r.timed_out = 1'b0;
          if (req_i.tmo == 32'h0000_0000)
          begin
            nxt_r.st        = WS_DONE;
            nxt_r.timed_out = 1'b1;
          end
          else if (lvl_now)
            nxt_r.st = WS_DONE;
          else
            nxt_r.st = WS_RUN;
        end
      end
      WS_RUN:
      begin
        nxt_r.prev = sig_i;
        if (hit)
          nxt_r.st = WS_DONE;
        else if (!r_ff.inf && r_ff.cnt == 32'h0000_0001)
        begin
          nxt_r.st        = WS_DONE;
          nxt_r.timed_out = 1'b1;
        end
        else if (!r_ff.inf)
          nxt_r.cnt = r_ff.cnt - 32'h0000_0001;
      end
      WS_DONE:
        nxt_r.st = WS_IDLE;
      default:
        nxt_r.st = WS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      r_ff <= '{st: WS_IDLE, mode: WAIT_RISE, default: '0};
    else if (ce_i)
      r_ff <= nxt_r;
  end

  assign rsp_o.busy      = (r_ff.st != WS_IDLE);
  assign rsp_o.done      = (r_ff.st == WS_DONE);
  assign rsp_o.timed_out = r_ff.timed_out;

endmodule : wait_engine
